// ===== tpg_defines.svh
// constants for the timer-three pwm generator
`ifndef TPG_DEFINES_SVH
`define TPG_DEFINES_SVH
`define TPG_OFF_PERIOD_LOW 12'h000
`define TPG_OFF_DUTY_LOW   12'h004
`define TPG_OFF_HIGH_BITS  12'h008
`define TPG_OFF_MODE       12'h00C
`define TPG_OFF_PORT_SEL   12'h010
`define TPG_OFF_STATUS     12'h014
`define TPG_MODE_RUN_BIT   0
`define TPG_MODE_POL_BIT   1
`define TPG_MODE_EN_BIT    2
`define TPG_MODE_CK_LSB    3
`define TPG_MODE_CK_MSB    4
`define TPG_PSEL_PIN_BIT   7
`define TPG_HI_PER_MSB     3
`define TPG_HI_PER_LSB     2
`define TPG_HI_DUTY_MSB    1
`define TPG_HI_DUTY_LSB    0
`define TPG_RESET_BYTE     8'h00
`define TPG_DIV_CK0        6'h00
`define TPG_DIV_CK1        6'h03
`define TPG_DIV_CK2        6'h0F
`define TPG_DIV_CK3        6'h3F
`endif

// ===== tpg_pkg.sv
// types for the timer-three pwm generator
package tpg_pkg;
  typedef enum logic [1:0] {
    TPG_IDLE  = 2'b00,
    TPG_RUN   = 2'b01,
    TPG_SQUARE = 2'b11
  } tpg_state_t;
endpackage

// ===== tpg_prescaler.sv
// source clock tick generator for timer three
`timescale 1ns/100ps
`default_nettype none
`include "tpg_defines.svh"
module tpg_prescaler (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       clk_en,
  input  wire logic       run,
  input  wire logic [1:0] clk_sel,
  output logic            tick
);
  logic [5:0] div_reg;
  logic [5:0] limit;

  always_comb begin
    unique case (clk_sel)
      2'b00: limit = `TPG_DIV_CK0;
      2'b01: limit = `TPG_DIV_CK1;
      2'b10: limit = `TPG_DIV_CK2;
      2'b11: limit = `TPG_DIV_CK3;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= 6'h00;
    end else if (clk_en) begin
      if (!run || div_reg >= limit) begin
        div_reg <= 6'h00;
      end else begin
        div_reg <= div_reg + 6'h01;
      end
    end
  end

  assign tick = clk_en && run && (div_reg >= limit);
endmodule
`default_nettype wire

// ===== tpg_counter.sv
// shared timer-three ten-bit counter with period match
`timescale 1ns/100ps
`default_nettype none
module tpg_counter #(
  parameter int WIDTH = 10
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             clk_en,
  input  wire logic             run,
  input  wire logic             tick,
  input  wire logic [WIDTH-1:0] period,
  output logic      [WIDTH-1:0] count,
  output logic                  match
);
  assign match = tick && (count >= period);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else if (clk_en) begin
      if (!run) begin
        count <= '0;
      end else if (match) begin
        count <= '0;
      end else if (tick) begin
        count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule
`default_nettype wire

// ===== tpg_top.sv
// apb-accessed timer-three pwm generator top
//
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "tpg_defines.svh"
module tpg_top #(
  parameter int RES = 10
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             modulator_output_pin,
  output logic             port5_bit4_pin
);
  // ==========================================================
  // register bus
  logic [7:0] pwm_period_low_reg;
  logic [7:0] pwm_duty_low_reg;
  logic [7:0] pwm_high_bits_reg;
  logic [7:0] timer_three_mode_reg;
  logic [7:0] port_selection_reg;
  logic       wr_en;
  logic       rd_en;
  logic       addr_ok;

  assign pready  = 1'b1;
  assign addr_ok = (paddr == `TPG_OFF_PERIOD_LOW) || (paddr == `TPG_OFF_DUTY_LOW) ||
                   (paddr == `TPG_OFF_HIGH_BITS) || (paddr == `TPG_OFF_MODE) ||
                   (paddr == `TPG_OFF_PORT_SEL) || (paddr == `TPG_OFF_STATUS);
  assign wr_en   = clk_en && psel && penable && pwrite;
  // read data captured in setup so it stands at the access edge
  assign rd_en   = clk_en && psel && !penable && !pwrite;
  assign pslverr = psel && penable && !addr_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_period_low_reg   <= `TPG_RESET_BYTE;
      pwm_duty_low_reg     <= `TPG_RESET_BYTE;
      pwm_high_bits_reg    <= `TPG_RESET_BYTE;
      timer_three_mode_reg <= `TPG_RESET_BYTE;
      port_selection_reg   <= `TPG_RESET_BYTE;
    end else if (wr_en) begin
      unique case (paddr)
        `TPG_OFF_PERIOD_LOW: pwm_period_low_reg <= pwdata[7:0];
        `TPG_OFF_DUTY_LOW:   pwm_duty_low_reg <= pwdata[7:0];
        `TPG_OFF_HIGH_BITS:  pwm_high_bits_reg <= {4'h0, pwdata[3:0]};
        `TPG_OFF_MODE:       timer_three_mode_reg <= {3'h0, pwdata[4:0]};
        `TPG_OFF_PORT_SEL:   port_selection_reg <= {pwdata[7], 7'h00};
        default: ;
      endcase
    end
  end

  // ==========================================================
  // mode decode
  logic       run;
  logic       active_level_select;
  logic       modulation_enable;
  logic [1:0] timer_three_clock_select;
  logic       pin_route;
  tpg_pkg::tpg_state_t state;

  assign run                      = timer_three_mode_reg[`TPG_MODE_RUN_BIT];
  assign active_level_select                      = timer_three_mode_reg[`TPG_MODE_POL_BIT];
  assign modulation_enable        = timer_three_mode_reg[`TPG_MODE_EN_BIT];
  assign timer_three_clock_select = timer_three_mode_reg[`TPG_MODE_CK_MSB:`TPG_MODE_CK_LSB];
  assign pin_route                = port_selection_reg[`TPG_PSEL_PIN_BIT];

  always_comb begin
    if (!run) begin
      state = tpg_pkg::TPG_IDLE;
    end else if (modulation_enable) begin
      state = tpg_pkg::TPG_RUN;
    end else begin
      state = tpg_pkg::TPG_SQUARE;
    end
  end

  // ==========================================================
  // ten-bit period and duty
  logic [RES-1:0] period_val;
  logic [RES-1:0] duty_master;
  logic [RES-1:0] duty_slave_reg;
  logic [RES-1:0] count;
  logic           tick;
  logic           match;

  assign period_val  = {pwm_high_bits_reg[`TPG_HI_PER_MSB:`TPG_HI_PER_LSB],
                        pwm_period_low_reg};
  assign duty_master = {pwm_high_bits_reg[`TPG_HI_DUTY_MSB:`TPG_HI_DUTY_LSB],
                        pwm_duty_low_reg};

  tpg_prescaler u_pre (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .run     (run),
    .clk_sel (timer_three_clock_select),
    .tick    (tick)
  );

  tpg_counter #(.WIDTH(RES)) u_cnt (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .run     (run),
    .tick    (tick),
    .period  (period_val),
    .count   (count),
    .match   (match)
  );

  // duty slave loads on period match, or while stopped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_slave_reg <= '0;
    end else if (clk_en) begin
      if (!run || match) begin
        duty_slave_reg <= duty_master;
      end
    end
  end

  // ==========================================================
  // output waveform
  logic active;
  logic pwm_level;
  logic square_reg;
  logic pin_reg;

  always_comb begin
    if (duty_slave_reg == '0) begin
      active = 1'b0;
    end else if (duty_slave_reg >= period_val) begin
      active = 1'b1;
    end else begin
      active = (count < duty_slave_reg);
    end
  end

  assign pwm_level = active_level_select ? active : !active;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      square_reg <= 1'b0;
    end else if (clk_en) begin
      if (state != tpg_pkg::TPG_SQUARE) begin
        square_reg <= 1'b0;
      end else if (match) begin
        square_reg <= !square_reg;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_reg <= 1'b0;
    end else if (clk_en) begin
      unique case (state)
        tpg_pkg::TPG_IDLE:   pin_reg <= !active_level_select;
        tpg_pkg::TPG_RUN:    pin_reg <= pwm_level;
        tpg_pkg::TPG_SQUARE: pin_reg <= square_reg;
        default:             pin_reg <= 1'b0;
      endcase
    end
  end

  assign modulator_output_pin = pin_reg;
  assign port5_bit4_pin       = pin_route && pin_reg;

  // ==========================================================
  // read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      unique case (paddr)
        `TPG_OFF_PERIOD_LOW: prdata <= {24'h00_0000, pwm_period_low_reg};
        `TPG_OFF_DUTY_LOW:   prdata <= {24'h00_0000, pwm_duty_low_reg};
        `TPG_OFF_HIGH_BITS:  prdata <= {24'h00_0000, pwm_high_bits_reg};
        `TPG_OFF_MODE:       prdata <= {24'h00_0000, timer_three_mode_reg};
        `TPG_OFF_PORT_SEL:   prdata <= {24'h00_0000, port_selection_reg};
        `TPG_OFF_STATUS:     prdata <= {5'h00, pin_reg, duty_slave_reg, 6'h00, count};
        default:             prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // tick spacing watch
  logic [5:0] gap_reg;
  logic [5:0] gap_next;
  logic [5:0] gap_limit;

  always_comb begin
    unique case (timer_three_clock_select)
      2'b00: gap_limit = `TPG_DIV_CK0;
      2'b01: gap_limit = `TPG_DIV_CK1;
      2'b10: gap_limit = `TPG_DIV_CK2;
      2'b11: gap_limit = `TPG_DIV_CK3;
    endcase
  end

  always_comb begin
    if (!run || tick) begin
      gap_next = 6'h00;
    end else begin
      gap_next = gap_reg + 6'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_reg <= 6'h00;
    end else if (clk_en) begin
      gap_reg <= gap_next;
    end
  end

  // ==========================================================
  // step sequences
  sequence s_period_end;
    clk_en && run && match;
  endsequence

  sequence s_fresh_period;
    (count == '0) && (duty_slave_reg == $past(duty_master));
  endsequence

  sequence s_mid_period;
    clk_en && run && !match;
  endsequence

  sequence s_duty_write;
    wr_en && ((paddr == `TPG_OFF_DUTY_LOW) || (paddr == `TPG_OFF_HIGH_BITS));
  endsequence

  sequence s_period_write;
    wr_en && (paddr == `TPG_OFF_PERIOD_LOW);
  endsequence

  // ==========================================================
  // checks
  a_slave_holds: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && run && !match) |=> $stable(duty_slave_reg))
    else $error("duty slave changed mid period");
  a_slave_loads: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && run && match) |=> (duty_slave_reg == $past(duty_master)))
    else $error("duty slave not loaded on match");
  a_count_wraps: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && run && match) |=> (count == '0))
    else $error("count not cleared on match");
  a_zero_duty: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && state == tpg_pkg::TPG_RUN && duty_slave_reg == '0)
      |=> (pin_reg == !$past(active_level_select)))
    else $error("zero duty level wrong");
  a_full_duty: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && state == tpg_pkg::TPG_RUN && duty_slave_reg != '0 &&
     duty_slave_reg == period_val) |=> (pin_reg == $past(active_level_select)))
    else $error("full duty level wrong");
  a_active_phase: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && state == tpg_pkg::TPG_RUN && duty_slave_reg != '0 &&
     duty_slave_reg < period_val && count < duty_slave_reg)
      |=> (pin_reg == $past(active_level_select)))
    else $error("active phase level wrong");
  a_idle_phase: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && state == tpg_pkg::TPG_RUN && duty_slave_reg != '0 &&
     duty_slave_reg < period_val && count >= duty_slave_reg)
      |=> (pin_reg == !$past(active_level_select)))
    else $error("inactive phase level wrong");
  a_period_form: assert property (@(posedge pclk) disable iff (!presetn)
    period_val[RES-1:RES-2] == pwm_high_bits_reg[3:2])
    else $error("period high bits misplaced");
  a_duty_form: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && !run) |=> (duty_slave_reg[1:0] == $past(pwm_duty_low_reg[1:0])))
    else $error("duty low bits misplaced");
  a_count_bound: assert property (@(posedge pclk) disable iff (!presetn)
    (run && modulation_enable) |-> (count <= period_val || !$stable(period_val)))
    else $error("count beyond period");
  a_new_period: assert property (@(posedge pclk) disable iff (!presetn)
    s_period_end |=> s_fresh_period)
    else $error("new period did not start cleanly");
  a_duty_waits: assert property (@(posedge pclk) disable iff (!presetn)
    (s_mid_period ##0 s_duty_write) |=> $stable(duty_slave_reg))
    else $error("duty write applied mid period");
  a_period_keeps: assert property (@(posedge pclk) disable iff (!presetn)
    (s_mid_period ##0 s_period_write) |=> $stable(duty_slave_reg))
    else $error("period write disturbed duty");
  a_idle_level: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && !run) |=> (pin_reg == !$past(active_level_select)))
    else $error("stopped level wrong");
  a_stop_follow: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && !run) |=> (duty_slave_reg == $past(duty_master)))
    else $error("stopped duty not following");
  a_square_flip: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && state == tpg_pkg::TPG_SQUARE && match) |=> (square_reg != $past(square_reg)))
    else $error("square wave did not toggle");
  a_square_rest: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && state != tpg_pkg::TPG_SQUARE) |=> !square_reg)
    else $error("square wave not parked");
  a_square_pin: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && state == tpg_pkg::TPG_SQUARE) |=> (pin_reg == $past(square_reg)))
    else $error("square wave not on pin");
  a_route_gate: assert property (@(posedge pclk) disable iff (!presetn)
    port5_bit4_pin == (pin_route && modulator_output_pin))
    else $error("shared pin routing wrong");
  a_count_step: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && run && tick && !match) |=> (count == $past(count) + 1'b1))
    else $error("count did not step");
  a_count_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && run && !tick) |=> $stable(count))
    else $error("count moved without tick");
  a_frozen_state: assert property (@(posedge pclk) disable iff (!presetn)
    !clk_en |=> ($stable(count) && $stable(duty_slave_reg) && $stable(pin_reg)))
    else $error("state moved while frozen");
  a_tick_spacing: assert property (@(posedge pclk) disable iff (!presetn)
    (run && tick) |-> (gap_reg >= gap_limit))
    else $error("tick came too early");
  a_tick_early: assert property (@(posedge pclk) disable iff (!presetn)
    (run && gap_reg < gap_limit) |-> !tick)
    else $error("tick inside divider span");
  a_write_period: assert property (@(posedge pclk) disable iff (!presetn)
    s_period_write |=> (pwm_period_low_reg == $past(pwdata[7:0])))
    else $error("period low write lost");
  a_write_duty: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == `TPG_OFF_DUTY_LOW) |=> (pwm_duty_low_reg == $past(pwdata[7:0])))
    else $error("duty low write lost");
  a_write_high: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == `TPG_OFF_HIGH_BITS)
      |=> (pwm_high_bits_reg == {4'h0, $past(pwdata[3:0])}))
    else $error("high bits write lost");
  a_read_period: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_en && paddr == `TPG_OFF_PERIOD_LOW)
      |=> (prdata == {24'h00_0000, $past(pwm_period_low_reg)}))
    else $error("period low read wrong");
  a_read_duty: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_en && paddr == `TPG_OFF_DUTY_LOW)
      |=> (prdata == {24'h00_0000, $past(pwm_duty_low_reg)}))
    else $error("duty low read wrong");
  a_read_high: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_en && paddr == `TPG_OFF_HIGH_BITS)
      |=> (prdata == {24'h00_0000, $past(pwm_high_bits_reg)}))
    else $error("high bits read wrong");
  a_read_status: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_en && paddr == `TPG_OFF_STATUS) |=> (prdata[25:16] == $past(duty_slave_reg)))
    else $error("status duty read wrong");
endmodule
`default_nettype wire

// ===== tb_timer3_pwm_generator.sv
// self-checking bench for the timer-three pwm generator
`timescale 1ns/100ps
`default_nettype none
`include "tpg_defines.svh"
module tb_timer3_pwm_generator;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        clk_en = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  wire logic [31:0] prdata;
  wire logic        pready;
  wire logic        pslverr;
  wire logic        pin;
  wire logic        port_pin;
  int          n_errors = 0;
  int          compares = 0;
  logic [31:0] rdat;
  logic        rerr;

  always #2.5 pclk = ~pclk;

  tpg_top i_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .modulator_output_pin(pin), .port5_bit4_pin(port_pin));

  // ==========================================
  // checking and closing
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("errors=%0d compares=%0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ==========================================
  // apb master
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    // answer taken at the edge that samples pready
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle edge keeps the next setup apart from this release
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask

  task automatic rd(input logic [11:0] a);
    apb(a, 1'b0, 32'h0);
  endtask

  // ==========================================
  // waveform expectation
  function automatic int divf(input logic [1:0] s);
    return (s == 2'd0) ? `TPG_DIV_CK0 + 1 : (s == 2'd1) ? `TPG_DIV_CK1 + 1 :
           (s == 2'd2) ? `TPG_DIV_CK2 + 1 : `TPG_DIV_CK3 + 1;
  endfunction

  function automatic int exp_hi(input int p, input int d, input logic active_level_select, input logic en,
                                input int dv);
    int l;
    int act;
    l = (p + 1) * dv;
    act = (d == 0) ? 0 : (d >= p) ? 2 * l : 2 * d * dv;
    if (!en) return l;
    return active_level_select ? act : 2 * l - act;
  endfunction

  // two whole periods after three settling periods
  task automatic meas(input int p, input int d, input logic active_level_select, input logic en,
                      input logic rt, input int dv);
    int l;
    int hi;
    int ph;
    l = (p + 1) * dv;
    hi = 0;
    ph = 0;
    repeat (3 * l) @(posedge pclk);
    repeat (2 * l) begin
      @(negedge pclk);
      hi += (pin === 1'b1);
      ph += (port_pin === 1'b1);
    end
    chk(hi, exp_hi(p, d, active_level_select, en, dv));
    chk(ph, rt ? exp_hi(p, d, active_level_select, en, dv) : 0);
    @(posedge pclk);
  endtask

  task automatic cfg(input logic [9:0] p, input logic [9:0] d, input logic active_level_select,
                     input logic en, input logic [1:0] s, input logic rt);
    wr(`TPG_OFF_MODE, {30'h0, active_level_select, 1'b0});
    repeat (2) @(posedge pclk);
    chk(pin, !active_level_select);
    wr(`TPG_OFF_PERIOD_LOW, 32'(p[7:0]));
    wr(`TPG_OFF_DUTY_LOW, 32'(d[7:0]));
    wr(`TPG_OFF_HIGH_BITS, {28'h0, p[9:8], d[9:8]});
    wr(`TPG_OFF_PORT_SEL, {24'h0, rt, 7'h0});
    rd(`TPG_OFF_HIGH_BITS);
    chk(rdat, {28'h0, p[9:8], d[9:8]});
    wr(`TPG_OFF_MODE, {27'h0, s, en, active_level_select, 1'b1});
    meas(p, d, active_level_select, en, rt, divf(s));
  endtask

  // ==========================================
  // main sequence
  initial begin
    logic [1:0] s;
    logic [9:0] p;
    logic [9:0] d;
    int         n;
    void'($urandom(32'h191E6E6F));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 5; i++) begin
      rd(12'(4 * i));
      chk(rdat, 32'(`TPG_RESET_BYTE));
    end
    chk(pin, 1'b1);
    chk(port_pin, 1'b0);
    rd(12'h020);
    chk(rdat, 32'h0);
    chk(32'(rerr), 32'h1);
    clk_en <= 1'b0;
    wr(`TPG_OFF_PERIOD_LOW, 32'h0000_00AA);
    clk_en <= 1'b1;
    rd(`TPG_OFF_PERIOD_LOW);
    chk(rdat, 32'h0);
    cfg(10'h105, 10'h102, 1'b1, 1'b1, 2'd0, 1'b1);
    cfg(10'd50, 10'd0, 1'b0, 1'b1, 2'd0, 1'b1);
    cfg(10'd50, 10'd50, 1'b1, 1'b1, 2'd1, 1'b1);
    cfg(10'd30, 10'd10, 1'b1, 1'b0, 2'd0, 1'b1);
    for (int i = 0; i < 8; i++) begin
      s = 2'($urandom % 4);
      p = 10'((s == 2'd0) ? 4 + $urandom % 500 : 4 + $urandom % 17);
      d = 10'($urandom % (p + 1));
      cfg(p, d, 1'($urandom), 1'b1, s, 1'($urandom));
    end
    cfg(10'd300, 10'd100, 1'b1, 1'b1, 2'd0, 1'b1);
    n = 0;
    do begin
      rd(`TPG_OFF_STATUS);
      n++;
    end while (rdat[9:0] > 10'd150 && n < 400);
    wr(`TPG_OFF_DUTY_LOW, 32'd50);
    rd(`TPG_OFF_STATUS);
    chk(32'(rdat[25:16]), 32'd100);
    meas(300, 50, 1'b1, 1'b1, 1'b1, 1);
    wr(`TPG_OFF_PERIOD_LOW, 32'h0000_0090);
    wr(`TPG_OFF_HIGH_BITS, 32'h0000_0004);
    meas(400, 50, 1'b1, 1'b1, 1'b1, 1);
    finish_test();
  end

  // hang guard, well beyond the expected run length
  initial begin
    #450_000;
    n_errors++;
    finish_test();
  end
endmodule
`default_nettype wire
